// >>> design/crtc_vertical_overflow_row_scan.sv
// Vertical timing, byte panning and preset row scan of the CRT controller
`timescale 1ns/100ps

// Function
// - Mode bit selects 10-bit or 12-bit values
// - Standard blank start: low, overflow3, maxscan5
// - Extended blank start upper nibble from extension
// - Standard sync start: low, overflow2, overflow7
// - Extended sync start upper nibble from extension
// - Standard display end: low, overflow1, overflow6
// - Extended display end upper nibble from extension
// - Standard total: low, overflow0, overflow5
// - Extended total upper nibble from extension
// - Line zero first active; blank, sync on match
// - Preset row scan bit 7 reads zero
// - Byte panning shifts image left 0-3 bytes
// - Shift steps nine or eight pixels per byte
// - Byte panning adds to fine pixel shift
// - Starting row scan picks first shown line
module crtc_vertical_overflow_row_scan
  import crtc_vert_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Indexed I/O port, same clock domain
  input  wire logic [15:0]            io_addr,
  input  wire logic                   io_wr,
  input  wire logic                   io_rd,
  input  wire logic [7:0]             io_wdata,
  output logic      [7:0]             io_rdata_q,
  // Raster pacing and display mode from the rest of the controller
  input  wire logic                   line_strobe,
  input  wire logic                   nine_dot_text,
  input  wire logic [3:0]             fine_pixel_shift,
  // Vertical timing outputs
  output logic      [VT_WIDTH-1:0]    line_count_q,
  output logic                        vdisp_en_q,
  output logic                        vblank_q,
  output logic                        vsync_q,
  output logic                        frame_start_q,
  // Text row scan and panning outputs
  output logic      [4:0]             row_scan_q,
  output logic      [SHIFT_WIDTH-1:0] pixel_shift_q
);

  // Register file state
  logic [7:0] index_q,           index_d;           // Selected index
  logic [7:0] vtotal_low_reg_q,  vtotal_low_reg_d;  // Total low byte
  logic [7:0] vert_overflow_q,   vert_overflow_d;   // Overflow bits
  logic [6:0] preset_row_q,      preset_row_d;      // Row scan and pan
  logic [7:0] max_scan_line_q,   max_scan_line_d;   // Max scan line
  logic [7:0] vsync_low_q,       vsync_low_d;       // Sync start low
  logic [7:0] vdisp_low_q,       vdisp_low_d;       // Display end low
  logic [7:0] vblank_low_q,      vblank_low_d;      // Blank start low
  logic [3:0] ext_vtotal_q,      ext_vtotal_d;      // Total upper nibble
  logic [3:0] ext_vdisp_q,       ext_vdisp_d;       // Disp end nibble
  logic [3:0] ext_vsync_q,       ext_vsync_d;       // Sync upper nibble
  logic [3:0] ext_vblank_q,      ext_vblank_d;      // Blank nibble
  logic [7:0] io_control_q,      io_control_d;      // Mode select
  logic [7:0] io_rdata_d;                           // Next read data

  // Port decode
  logic       hit_index;                            // Index port access
  logic       hit_data;                             // Data port access
  logic [7:0] reg_rd_value;                         // Selected register

  // Assembled vertical values, one per slot
  logic [7:0]          slot_low  [NUM_SLOTS];
  logic [3:0]          slot_ext  [NUM_SLOTS];
  logic                slot_b8   [NUM_SLOTS];
  logic                slot_b9   [NUM_SLOTS];
  logic [VT_WIDTH-1:0] slot_value[NUM_SLOTS];
  logic                ext_mode;                    // 12-bit mode

  // Raster state
  logic [VT_WIDTH-1:0]    line_count_d;
  logic                   vdisp_en_d;
  logic                   vblank_d;
  logic                   vsync_d;
  logic                   frame_start_d;
  logic [3:0]             sync_left_q, sync_left_d; // Sync lines to go
  logic [4:0]             row_scan_d;
  logic [SHIFT_WIDTH-1:0] pixel_shift_d;
  logic [SHIFT_WIDTH-1:0] shift_calc;               // Panning sum

  // Both monochrome and colour decodes are honoured at once
  always_comb begin
    hit_index = (io_addr == MONO_INDEX_ADDR)
             || (io_addr == COLOR_INDEX_ADDR);
    hit_data  = (io_addr == MONO_DATA_ADDR)
             || (io_addr == COLOR_DATA_ADDR);
  end

  // Readback mux; unknown indices read as zero
  always_comb begin
    unique case (index_q)
      IDX_VTOTAL_LOW:    reg_rd_value = vtotal_low_reg_q;
      IDX_VERT_OVERFLOW: reg_rd_value = vert_overflow_q;
      IDX_PRESET_ROW:    reg_rd_value = {1'b0, preset_row_q};
      IDX_MAX_SCAN:      reg_rd_value = max_scan_line_q;
      IDX_VSYNC_LOW:     reg_rd_value = vsync_low_q;
      IDX_VDISP_LOW:     reg_rd_value = vdisp_low_q;
      IDX_VBLANK_LOW:    reg_rd_value = vblank_low_q;
      IDX_EXT_VTOTAL:    reg_rd_value = {4'h0, ext_vtotal_q};
      IDX_EXT_VDISP:     reg_rd_value = {4'h0, ext_vdisp_q};
      IDX_EXT_VSYNC:     reg_rd_value = {4'h0, ext_vsync_q};
      IDX_EXT_VBLANK:    reg_rd_value = {4'h0, ext_vblank_q};
      IDX_IO_CONTROL:    reg_rd_value = io_control_q;
      default:           reg_rd_value = RESET_BYTE;
    endcase
  end

  // Next values of the register file and the read data
  always_comb begin
    index_d          = index_q;
    vtotal_low_reg_d = vtotal_low_reg_q;
    vert_overflow_d  = vert_overflow_q;
    preset_row_d     = preset_row_q;
    max_scan_line_d  = max_scan_line_q;
    vsync_low_d      = vsync_low_q;
    vdisp_low_d      = vdisp_low_q;
    vblank_low_d     = vblank_low_q;
    ext_vtotal_d     = ext_vtotal_q;
    ext_vdisp_d      = ext_vdisp_q;
    ext_vsync_d      = ext_vsync_q;
    ext_vblank_d     = ext_vblank_q;
    io_control_d     = io_control_q;
    io_rdata_d       = io_rdata_q;
    // Index port write picks the register behind the data port
    if (io_wr && hit_index) begin
      index_d = io_wdata;
    end
    // Data port write lands in the selected register
    if (io_wr && hit_data) begin
      unique case (index_q)
        IDX_VTOTAL_LOW:    vtotal_low_reg_d = io_wdata;
        IDX_VERT_OVERFLOW: vert_overflow_d  = io_wdata;
        IDX_PRESET_ROW:    preset_row_d     = io_wdata[6:0];
        IDX_MAX_SCAN:      max_scan_line_d  = io_wdata;
        IDX_VSYNC_LOW:     vsync_low_d      = io_wdata;
        IDX_VDISP_LOW:     vdisp_low_d      = io_wdata;
        IDX_VBLANK_LOW:    vblank_low_d     = io_wdata;
        IDX_EXT_VTOTAL:    ext_vtotal_d     = io_wdata[3:0];
        IDX_EXT_VDISP:     ext_vdisp_d      = io_wdata[3:0];
        IDX_EXT_VSYNC:     ext_vsync_d      = io_wdata[3:0];
        IDX_EXT_VBLANK:    ext_vblank_d     = io_wdata[3:0];
        IDX_IO_CONTROL:    io_control_d     = io_wdata;
        // Writes to indices outside this block are dropped
        default:           io_control_d     = io_control_q;
      endcase
    end
    // Reads answer one cycle after the strobe
    if (io_rd && hit_index) begin
      io_rdata_d = index_q;
    end else if (io_rd && hit_data) begin
      io_rdata_d = reg_rd_value;
    end
  end

  // Register file flops
  always_ff @(posedge clk) begin
    if (reset) begin
      index_q          <= RESET_BYTE;
      vtotal_low_reg_q <= RESET_BYTE;
      vert_overflow_q  <= RESET_BYTE;
      preset_row_q     <= RESET_BYTE[6:0];
      max_scan_line_q  <= RESET_BYTE;
      vsync_low_q      <= RESET_BYTE;
      vdisp_low_q      <= RESET_BYTE;
      vblank_low_q     <= RESET_BYTE;
      ext_vtotal_q     <= RESET_NIBBLE;
      ext_vdisp_q      <= RESET_NIBBLE;
      ext_vsync_q      <= RESET_NIBBLE;
      ext_vblank_q     <= RESET_NIBBLE;
      io_control_q     <= RESET_BYTE;
      io_rdata_q       <= RESET_BYTE;
    end else begin
      index_q          <= index_d;
      vtotal_low_reg_q <= vtotal_low_reg_d;
      vert_overflow_q  <= vert_overflow_d;
      preset_row_q     <= preset_row_d;
      max_scan_line_q  <= max_scan_line_d;
      vsync_low_q      <= vsync_low_d;
      vdisp_low_q      <= vdisp_low_d;
      vblank_low_q     <= vblank_low_d;
      ext_vtotal_q     <= ext_vtotal_d;
      ext_vdisp_q      <= ext_vdisp_d;
      ext_vsync_q      <= ext_vsync_d;
      ext_vblank_q     <= ext_vblank_d;
      io_control_q     <= io_control_d;
      io_rdata_q       <= io_rdata_d;
    end
  end

  // Width of every vertical value follows the mode bit
  assign ext_mode = io_control_q[IOC_EXT_MODE_BIT];

  // Route the pieces of each vertical value to its assembler slot
  always_comb begin
    // Total
    slot_low[SLOT_TOTAL] = vtotal_low_reg_q;
    slot_ext[SLOT_TOTAL] = ext_vtotal_q;
    slot_b8[SLOT_TOTAL]  = vert_overflow_q[OV_VTOTAL_B8];
    slot_b9[SLOT_TOTAL]  = vert_overflow_q[OV_VTOTAL_B9];
    // Display enable end
    slot_low[SLOT_DISP_END] = vdisp_low_q;
    slot_ext[SLOT_DISP_END] = ext_vdisp_q;
    slot_b8[SLOT_DISP_END]  = vert_overflow_q[OV_VDISP_B8];
    slot_b9[SLOT_DISP_END]  = vert_overflow_q[OV_VDISP_B9];
    // Blanking start, bit 9 lives in the max scan line register
    slot_low[SLOT_BLANK] = vblank_low_q;
    slot_ext[SLOT_BLANK] = ext_vblank_q;
    slot_b8[SLOT_BLANK]  = vert_overflow_q[OV_VBLANK_B8];
    slot_b9[SLOT_BLANK]  = max_scan_line_q[MS_VBLANK_B9];
    // Sync start
    slot_low[SLOT_SYNC] = vsync_low_q;
    slot_ext[SLOT_SYNC] = ext_vsync_q;
    slot_b8[SLOT_SYNC]  = vert_overflow_q[OV_VSYNC_B8];
    slot_b9[SLOT_SYNC]  = vert_overflow_q[OV_VSYNC_B9];
  end

  // One assembler per vertical value; overflow ignored in 12-bit mode
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    vt_field_assemble u_assemble (
      .low_bits (slot_low[s]),
      .ext_bits (slot_ext[s]),
      .ov_bit8  (slot_b8[s]),
      .ov_bit9  (slot_b9[s]),
      .ext_mode (ext_mode),
      .value    (slot_value[s])
    );
  end

  // Byte panning scaled by box width plus the fine shift
  pan_shift_calc u_pan (
    .byte_pan    (preset_row_q[PR_BYTE_PAN_HI:PR_BYTE_PAN_LO]),
    .nine_dot    (nine_dot_text),
    .fine_shift  (fine_pixel_shift),
    .total_shift (shift_calc)
  );

  // Raster next state: counter, compares, sync length, row scan
  always_comb begin
    line_count_d  = line_count_q;
    vdisp_en_d    = vdisp_en_q;
    vblank_d      = vblank_q;
    vsync_d       = vsync_q;
    sync_left_d   = sync_left_q;
    row_scan_d    = row_scan_q;
    frame_start_d = 1'b0;
    pixel_shift_d = shift_calc;
    if (line_strobe) begin
      if (line_count_q == slot_value[SLOT_TOTAL]) begin
        // Wrap after the total line; new frame starts at line zero
        line_count_d  = '0;
        frame_start_d = 1'b1;
        // Top text row may start part way into its box
        row_scan_d    = preset_row_q[PR_ROW_HI:PR_ROW_LO];
      end else begin
        line_count_d  = line_count_q + 1'b1;
        // Row scan wraps at the maximum scan line of a text row
        if (row_scan_q == max_scan_line_q[4:0]) begin
          row_scan_d = '0;
        end else begin
          row_scan_d = row_scan_q + 1'b1;
        end
      end
      // Active from line zero through the display end line
      vdisp_en_d = (line_count_d <= slot_value[SLOT_DISP_END]);
      // Blanking begins on the matching line and holds to the wrap
      if (line_count_d == slot_value[SLOT_BLANK]) begin
        vblank_d = 1'b1;
      end else if (frame_start_d) begin
        vblank_d = 1'b0;
      end
      // Sync begins on the matching line and runs a fixed count
      if (line_count_d == slot_value[SLOT_SYNC]) begin
        vsync_d     = 1'b1;
        sync_left_d = VSYNC_LINES - 4'h1;
      end else if (sync_left_q != 4'h0) begin
        sync_left_d = sync_left_q - 4'h1;
      end else begin
        vsync_d     = 1'b0;
      end
    end
  end

  // Raster flops; line zero is the first active line after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      line_count_q  <= '0;
      vdisp_en_q    <= 1'b1;
      vblank_q      <= 1'b0;
      vsync_q       <= 1'b0;
      sync_left_q   <= 4'h0;
      frame_start_q <= 1'b0;
      row_scan_q    <= 5'h00;
      pixel_shift_q <= '0;
    end else begin
      line_count_q  <= line_count_d;
      vdisp_en_q    <= vdisp_en_d;
      vblank_q      <= vblank_d;
      vsync_q       <= vsync_d;
      sync_left_q   <= sync_left_d;
      frame_start_q <= frame_start_d;
      row_scan_q    <= row_scan_d;
      pixel_shift_q <= pixel_shift_d;
    end
  end

endmodule

// >>> shared/crtc_vert_pkg.sv
// Constants shared by the vertical timing and panning block
package crtc_vert_pkg;

  // Indexed I/O port addresses (monochrome and colour decodes)
  localparam logic [15:0] MONO_INDEX_ADDR   = 16'h03b4;
  localparam logic [15:0] MONO_DATA_ADDR    = 16'h03b5;
  localparam logic [15:0] COLOR_INDEX_ADDR  = 16'h03d4;
  localparam logic [15:0] COLOR_DATA_ADDR   = 16'h03d5;

  // Register indices behind the data port
  localparam logic [7:0] IDX_VTOTAL_LOW     = 8'h06;
  localparam logic [7:0] IDX_VERT_OVERFLOW  = 8'h07;
  localparam logic [7:0] IDX_PRESET_ROW     = 8'h08;
  localparam logic [7:0] IDX_MAX_SCAN       = 8'h09;
  localparam logic [7:0] IDX_VSYNC_LOW      = 8'h10;
  localparam logic [7:0] IDX_VDISP_LOW      = 8'h12;
  localparam logic [7:0] IDX_VBLANK_LOW     = 8'h15;
  localparam logic [7:0] IDX_EXT_VTOTAL     = 8'h30;
  localparam logic [7:0] IDX_EXT_VDISP      = 8'h31;
  localparam logic [7:0] IDX_EXT_VSYNC      = 8'h32;
  localparam logic [7:0] IDX_EXT_VBLANK     = 8'h33;
  localparam logic [7:0] IDX_IO_CONTROL     = 8'h80;

  // Reset values
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [3:0] RESET_NIBBLE       = 4'h0;

  // Field positions: io control, overflow, max scan line, preset row
  localparam int IOC_EXT_MODE_BIT           = 0;
  localparam int OV_VTOTAL_B8               = 0;
  localparam int OV_VDISP_B8                = 1;
  localparam int OV_VSYNC_B8                = 2;
  localparam int OV_VBLANK_B8               = 3;
  localparam int OV_VTOTAL_B9               = 5;
  localparam int OV_VDISP_B9                = 6;
  localparam int OV_VSYNC_B9                = 7;
  localparam int MS_VBLANK_B9               = 5;
  localparam int PR_BYTE_PAN_HI             = 6;
  localparam int PR_BYTE_PAN_LO             = 5;
  localparam int PR_ROW_HI                  = 4;
  localparam int PR_ROW_LO                  = 0;

  // Which vertical value each assembler slot builds
  localparam int SLOT_TOTAL                 = 0;
  localparam int SLOT_DISP_END              = 1;
  localparam int SLOT_BLANK                 = 2;
  localparam int SLOT_SYNC                  = 3;
  localparam int NUM_SLOTS                  = 4;

  // Widths and timing
  localparam int VT_WIDTH                   = 12;
  localparam int SHIFT_WIDTH                = 6;
  localparam logic [5:0] PIX_PER_BYTE_9     = 6'h09;
  localparam logic [5:0] PIX_PER_BYTE_8     = 6'h08;
  localparam logic [3:0] VSYNC_LINES        = 4'h2;

endpackage

// >>> design/vt_field_assemble.sv
// Builds one 10-bit or 12-bit vertical timing value from its pieces
`timescale 1ns/100ps
module vt_field_assemble
  import crtc_vert_pkg::*;
(
  // Pieces of the value
  input  wire logic [7:0]          low_bits,
  input  wire logic [3:0]          ext_bits,
  input  wire logic                ov_bit8,
  input  wire logic                ov_bit9,
  // Mode select, 1 = extended 12-bit
  input  wire logic                ext_mode,
  // Assembled value
  output logic      [VT_WIDTH-1:0] value
);

  // Extended mode ignores the overflow bits entirely, so stale overflow
  // contents from a standard mode never leak into the upper nibble
  always_comb begin
    if (ext_mode) begin
      value = {ext_bits, low_bits};
    end else begin
      value = {2'b00, ov_bit9, ov_bit8, low_bits};
    end
  end

endmodule

// >>> design/pan_shift_calc.sv
// Combines byte panning with the fine pixel shift into one pixel count
`timescale 1ns/100ps
module pan_shift_calc
  import crtc_vert_pkg::*;
(
  // Panning controls
  input  wire logic [1:0]             byte_pan,
  input  wire logic                   nine_dot,
  input  wire logic [3:0]             fine_shift,
  // Total left shift in pixels
  output logic      [SHIFT_WIDTH-1:0] total_shift
);

  // Width of one byte column on screen
  logic [SHIFT_WIDTH-1:0] byte_width;

  // Byte panning scales by the box width, then the fine shift adds on top
  always_comb begin
    byte_width  = nine_dot ? PIX_PER_BYTE_9 : PIX_PER_BYTE_8;
    total_shift = SHIFT_WIDTH'(byte_width * byte_pan)
                + SHIFT_WIDTH'(fine_shift);
  end

endmodule

// >>> dv/crtc_vert_assertions.sv
// Port-level checker for the vertical timing and panning block
`timescale 1ns/100ps
module crtc_vert_assertions
  import crtc_vert_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // Register port
  input wire logic [15:0]            io_addr,
  input wire logic                   io_wr,
  input wire logic                   io_rd,
  input wire logic [7:0]             io_wdata,
  input wire logic [7:0]             io_rdata_q,
  // Raster pacing and mode
  input wire logic                   line_strobe,
  input wire logic                   nine_dot_text,
  input wire logic [3:0]             fine_pixel_shift,
  // Timing and panning outputs
  input wire logic [VT_WIDTH-1:0]    line_count_q,
  input wire logic                   vdisp_en_q,
  input wire logic                   vblank_q,
  input wire logic                   vsync_q,
  input wire logic                   frame_start_q,
  input wire logic [4:0]             row_scan_q,
  input wire logic [SHIFT_WIDTH-1:0] pixel_shift_q
);
  logic [7:0]             idx_q, idx_d;   // Shadow of the index byte
  logic [6:0]             prs_q, prs_d;   // Shadow of pan and preset row
  logic [1:0]             sy_q, sy_d;     // Strobes seen while sync high
  logic [SHIFT_WIDTH-1:0] sh_exp;         // Shift the inputs call for
  wire is_idx = io_addr == MONO_INDEX_ADDR || io_addr == COLOR_INDEX_ADDR;
  wire is_dat = io_addr == MONO_DATA_ADDR || io_addr == COLOR_DATA_ADDR;

  // Next shadow values; data writes use the old index
  always_comb begin
    idx_d = (io_wr && is_idx) ? io_wdata : idx_q;
    prs_d = (io_wr && is_dat && idx_q == IDX_PRESET_ROW) ? io_wdata[6:0]
                                                         : prs_q;
    sy_d = !vsync_q ? 2'h0 : (line_strobe ? sy_q + 2'h1 : sy_q);
    sh_exp = SHIFT_WIDTH'(prs_q[6:5])
           * (nine_dot_text ? PIX_PER_BYTE_9 : PIX_PER_BYTE_8)
           + SHIFT_WIDTH'(fine_pixel_shift);
  end

  // Shadow registers, cleared with the block
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_q <= 8'h00;
      prs_q <= 7'h00;
      sy_q  <= 2'h0;
    end else begin
      idx_q <= idx_d;
      prs_q <= prs_d;
      sy_q  <= sy_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Strobes inside one sync pulse
  sequence s_sync_first;
    vsync_q && line_strobe && sy_q == 2'h0;
  endsequence
  sequence s_sync_second;
    vsync_q && line_strobe && sy_q == 2'h1;
  endsequence

  a_rsv_bit_zero: assert property (
    io_rd && is_dat && idx_q == IDX_PRESET_ROW |=> !io_rdata_q[7])
    else $error("reserved bit read as one");
  a_line_advance: assert property (
    line_strobe |=> line_count_q ==
      (frame_start_q ? '0 : $past(line_count_q) + 1'b1))
    else $error("line count did not step");
  a_line_hold: assert property (
    !line_strobe |=> $stable({line_count_q, vdisp_en_q, vblank_q,
                              vsync_q, row_scan_q}) && !frame_start_q)
    else $error("raster moved unstrobed");
  a_frame_zero: assert property (
    frame_start_q |-> line_count_q == '0 && $past(line_strobe))
    else $error("frame start off wrap");
  a_frame_first: assert property (
    frame_start_q |-> vdisp_en_q)
    else $error("line zero inactive");
  a_row_preset: assert property (
    frame_start_q |-> row_scan_q == $past(prs_q[4:0]))
    else $error("row scan missed preset");
  a_pan_total: assert property (
    !$past(reset) |-> pixel_shift_q == $past(sh_exp))
    else $error("pixel shift wrong");
  a_sync_stays: assert property (
    s_sync_first |=> vsync_q)
    else $error("sync too short");
  a_sync_ends: assert property (
    s_sync_second |=> !vsync_q)
    else $error("sync too long");
endmodule

bind crtc_vertical_overflow_row_scan crtc_vert_assertions u_chk (
  .clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q,
  .line_strobe, .nine_dot_text, .fine_pixel_shift, .line_count_q,
  .vdisp_en_q, .vblank_q, .vsync_q, .frame_start_q, .row_scan_q,
  .pixel_shift_q);

// >>> dv/crtc_host_model.sv
// Host software and line pacing model in front of the block
`timescale 1ns/100ps
module crtc_host_model
  import crtc_vert_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Indexed register port
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata_q,
  // Scan line pacing
  output logic             line_strobe
);
  logic       run  = 1'b0; // Raster advancing
  logic [3:0] gap  = 4'h0; // Idle cycles between strobes, slow pacing
  logic [3:0] cnt  = 4'h0; // Cycles since last strobe
  logic       mono = 1'b0; // Alternates the two port decodes

  initial begin
    io_addr     = 16'h0000;
    io_wr       = 1'b0;
    io_rd       = 1'b0;
    io_wdata    = 8'h00;
    line_strobe = 1'b0;
  end

  // Strobe pacing, set just after each edge
  always @(posedge clk) begin
    cnt <= (run && cnt != gap) ? cnt + 4'h1 : 4'h0;
    line_strobe <= #1 run && cnt == gap;
  end

  // One access, held for one clock
  task automatic cyc(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    io_addr  = a;
    io_wdata = d;
    io_wr    = w;
    io_rd    = ~w;
    @(posedge clk);
    #1;
  endtask

  // Release: lines show inverted junk
  task automatic idle;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~io_addr;
    io_wdata = ~io_wdata;
    @(posedge clk);
    #1;
  endtask

  // Index then data write, back to back
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cyc(1'b1, mono ? MONO_INDEX_ADDR : COLOR_INDEX_ADDR, idx);
    cyc(1'b1, mono ? MONO_DATA_ADDR : COLOR_DATA_ADDR, d);
    mono = ~mono;
    idle();
  endtask

  // Index on one decode, read on the other
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    cyc(1'b1, COLOR_INDEX_ADDR, idx);
    cyc(1'b0, MONO_DATA_ADDR, 8'h00);
    q = io_rdata_q;
    idle();
  endtask

  // Frame set up the way software normally does it
  task automatic std_frame(input logic [7:0] lines, input logic [7:0] act);
    wr(IDX_VTOTAL_LOW, lines - 8'h02);
    wr(IDX_VDISP_LOW, act - 8'h01);
    wr(IDX_PRESET_ROW, 8'h00);
  endtask
endmodule

// >>> dv/crtc_vertical_overflow_row_scan_tb.sv
// Self-checking bench for the vertical timing and panning block
`timescale 1ns/100ps
module crtc_vertical_overflow_row_scan_tb
  import crtc_vert_pkg::*;
  ;
  // One case: mode, overflow, max scan, lows and nibbles (t,d,s,b),
  // then the four values the raster should show
  typedef struct packed {
    logic        mode;
    logic [7:0]  ov;
    logic [7:0]  ms;
    logic [31:0] lo;
    logic [15:0] ex;
    logic [47:0] ev;
  } row_t;
  row_t rows [4] = '{
    '{1'b0, 8'h0f, 8'h00, 32'h2008100c, 16'hffff, 48'h12010811010c},
    '{1'b0, 8'he0, 8'h20, 32'h2008100c, 16'h0000, 48'h22020821020c},
    '{1'b1, 8'hff, 8'h20, 32'h2008100c, 16'h0000, 48'h02000801000c},
    '{1'b1, 8'h00, 8'h00, 32'h2008100c, 16'hfeee, 48'hf20e08e10e0c}};
  logic [7:0] lo_idx [4] = '{IDX_VTOTAL_LOW, IDX_VDISP_LOW,
                             IDX_VSYNC_LOW, IDX_VBLANK_LOW};
  logic [7:0] ex_idx [4] = '{IDX_EXT_VTOTAL, IDX_EXT_VDISP,
                             IDX_EXT_VSYNC, IDX_EXT_VBLANK};
  logic                   clk, reset, io_wr, io_rd, line_strobe;
  logic [15:0]            io_addr;
  logic [7:0]             io_wdata, io_rdata_q, rv;
  logic                   nine_dot_text;
  logic [3:0]             fine_pixel_shift;
  logic [VT_WIDTH-1:0]    line_count_q;
  logic                   vdisp_en_q, vblank_q, vsync_q, frame_start_q;
  logic [4:0]             row_scan_q;
  logic [SHIFT_WIDTH-1:0] pixel_shift_q;
  logic [47:0]            got;   // Measured values t,d,s,b
  logic [15:0]            sw;    // Lines seen with sync high
  int                     n, n_fail, tests_run;

  crtc_vertical_overflow_row_scan u_dut (
    .clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q,
    .line_strobe, .nine_dot_text, .fine_pixel_shift, .line_count_q,
    .vdisp_en_q, .vblank_q, .vsync_q, .frame_start_q, .row_scan_q,
    .pixel_shift_q);
  crtc_host_model u_host (
    .clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q, .line_strobe);

  // 125 MHz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic step(inout int k);
    @(posedge clk);
    #1;
    k++;
  endtask

  // Three-cycle reset, raster stopped
  task automatic do_reset;
    u_host.run = 1'b0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("line_after_reset", 16'(line_count_q), 16'h0000);
    chk("vdisp_after_reset", 16'(vdisp_en_q), 16'h0001);
  endtask

  // Run to a wrap, then record one frame
  task automatic frame;
    n = 0;
    got = '0;
    sw = '0;
    u_host.run = 1'b1;
    while (frame_start_q !== 1'b1 && n < 5000) step(n);
    do begin
      if (vdisp_en_q === 1'b1) got[35:24] = line_count_q;
      if (vblank_q === 1'b1 && got[11:0] == '0) got[11:0] = line_count_q;
      if (vsync_q === 1'b1 && sw == '0) got[23:12] = line_count_q;
      if (vsync_q === 1'b1) sw++;
      got[47:36] = line_count_q;
      step(n);
    end while (frame_start_q !== 1'b1 && n < 10000);
    u_host.run = 1'b0;
  endtask

  // Hang guard, about twice the run length
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    nine_dot_text = 1'b0;
    fine_pixel_shift = 4'h0;
    do_reset();
    // Assembly cases, both widths
    foreach (rows[i]) begin
      do_reset();
      u_host.wr(IDX_IO_CONTROL, {7'h00, rows[i].mode});
      u_host.wr(IDX_VERT_OVERFLOW, rows[i].ov);
      u_host.wr(IDX_MAX_SCAN, rows[i].ms);
      for (int k = 0; k < 4; k++) begin
        u_host.wr(lo_idx[k], rows[i].lo[31-8*k -: 8]);
        u_host.wr(ex_idx[k], {4'h0, rows[i].ex[15-4*k -: 4]});
      end
      frame();
      chk("total", 16'(got[47:36]), 16'(rows[i].ev[47:36]));
      chk("disp_end", 16'(got[35:24]), 16'(rows[i].ev[35:24]));
      chk("sync_start", 16'(got[23:12]), 16'(rows[i].ev[23:12]));
      chk("blank_start", 16'(got[11:0]), 16'(rows[i].ev[11:0]));
      chk("sync_lines", sw, 16'h0002);
    end
    // Reads: reset, reserved bit, extension, unmapped
    do_reset();
    u_host.rd(IDX_PRESET_ROW, rv);
    chk("preset_reset", 16'(rv), 16'h0000);
    u_host.wr(IDX_PRESET_ROW, 8'hff);
    u_host.rd(IDX_PRESET_ROW, rv);
    chk("preset_rd", 16'(rv), 16'h007f);
    u_host.wr(IDX_EXT_VTOTAL, 8'hff);
    u_host.rd(IDX_EXT_VTOTAL, rv);
    chk("ext_rd", 16'(rv), 16'h000f);
    u_host.wr(8'h40, 8'hff);
    u_host.rd(8'h40, rv);
    chk("unmapped_rd", 16'(rv), 16'h0000);
    // Every pan code, both box widths, plus fine shift
    for (int p = 0; p < 8; p++) begin
      u_host.wr(IDX_PRESET_ROW, {1'b0, 2'(p % 4), 5'h00});
      nine_dot_text = 1'(p / 4);
      fine_pixel_shift = 4'(15 - 4 * (p % 4));
      @(posedge clk);
      #1;
      chk("pixel_shift", 16'(pixel_shift_q), 16'((p % 4) * (p / 4 ? 9 : 8)
          + 15 - 4 * (p % 4)));
    end
    // Preset row, slow pacing: start row, wrap at max scan
    do_reset();
    u_host.std_frame(8'h0c, 8'h08);
    u_host.wr(IDX_MAX_SCAN, 8'h05);
    u_host.wr(IDX_PRESET_ROW, 8'h03);
    u_host.gap = 4'h2;
    u_host.run = 1'b1;
    n = 0;
    while (frame_start_q !== 1'b1 && n < 200) step(n);
    chk("row_first", 16'(row_scan_q), 16'h0003);
    for (int j = 1; j < 5; j++) begin
      while (line_count_q !== 12'(j) && n < 400) step(n);
      chk("row_next", 16'(row_scan_q), 16'((3 + j) % 6));
    end
    test_done();
  end
endmodule
